// *** include/ssf_params.svh ***
// Constants of the serial adapter session flow: bytes, command codes, timing.
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSF_CLK_HZ 100000000
`define SSF_MS_CYC (`SSF_CLK_HZ / 1000)
`define SSF_LOCAL_WAIT_MS 100
`define SSF_REMOTE_WAIT_MS 1000
`define SSF_LIFE_MS 3000
`define SSF_ACK_WAIT_MS 1000
`define SSF_ACK_RETRY_MAX 3'h5

// ----------------------------------------------------------------------------
// Link and transport bytes
// ----------------------------------------------------------------------------
`define SSF_BYTE_ATTN 8'h01
`define SSF_BYTE_ACK 8'h06
`define SSF_BYTE_NACK 8'h15
`define SSF_BUFFER_GRANTED_REPLY 8'hC0
`define SSF_BUFFER_REFUSED_REPLY 8'hC1

// ----------------------------------------------------------------------------
// Command byte layout: class in the high nibble, queue in the low two bits
// ----------------------------------------------------------------------------
`define SSF_CLS_MSB 7
`define SSF_CLS_LSB 4
`define SSF_CLS_NETWORK_MSG 4'h1
`define SSF_CLS_LOCAL_MGMT 4'h2
`define SSF_IFACE_RESET_CMD 8'h50
`define SSF_FLUSH_CANCEL_CMD 8'h60
`define SSF_GO_ONLINE_CMD 8'h61
`define SSF_GO_OFFLINE_CMD 8'h62
`define SSF_FLUSH_CMD 8'h63
`define SSF_FLUSH_IGNORE_CMD 8'h64
`define SSF_UPLINK_QUENCH_CMD 8'h65
`define SSF_UPLINK_RESUME_CMD 8'h66
`define SSF_SLEEP_CMD 8'h67
`define SSF_STATUS_QUERY_CMD 8'h68

// Firmware level of this adapter and the least level that takes unrequested messages
`define SSF_FW_VERSION 8'h07
`define SSF_FW_UNREQ_MIN 8'h07

`endif

// *** include/ssf_pkg.sv ***
// Types of the serial adapter session flow.
package ssf_pkg;
    typedef enum logic [2:0] {
        SSF_UL_IDLE = 3'h0,
        SSF_UL_ATTN = 3'h1,
        SSF_UL_WAIT_ATTN = 3'h3,
        SSF_UL_BODY = 3'h2,
        SSF_UL_WAIT_END = 3'h6,
        SSF_UL_WAIT_ACK = 3'h7
    } ssf_ul_state_t;

    typedef enum logic [1:0] {
        SSF_DL_NORMAL = 2'h0,
        SSF_DL_REQUESTED = 2'h1,
        SSF_DL_GRANTED = 2'h3
    } ssf_dl_state_t;

    typedef enum logic [1:0] {
        SSF_TX_RAW = 2'h0,
        SSF_TX_REPLY = 2'h1,
        SSF_TX_MSG = 2'h2
    } ssf_tx_kind_t;

    typedef enum logic [1:0] {
        SSF_Q_ACKED = 2'h0,
        SSF_Q_ACKED_PRIORITY = 2'h1,
        SSF_Q_UNACKED = 2'h2,
        SSF_Q_UNACKED_PRIORITY = 2'h3
    } ssf_queue_t;
endpackage

// *** rtl/ssf_session_top.sv ***
// Session and transport control of the serial adapter toward the host.
`timescale 1ns/1ps
`include "ssf_params.svh"
module ssf_session_top #(
    parameter int LOCAL_WAIT_CYC = `SSF_LOCAL_WAIT_MS * `SSF_MS_CYC,
    parameter int REMOTE_WAIT_CYC = `SSF_REMOTE_WAIT_MS * `SSF_MS_CYC,
    parameter int LIFE_CYC = `SSF_LIFE_MS * `SSF_MS_CYC,
    parameter int ACK_WAIT_CYC = `SSF_ACK_WAIT_MS * `SSF_MS_CYC
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cfg_remote_in,
    input wire logic cfg_handshake_in,
    input wire logic dl_byte_in,
    input wire logic dl_frame_in,
    input wire logic [7:0] dl_cmd_in,
    input wire logic dl_has_data_in,
    input wire logic dl_good_in,
    input wire logic dl_attn_ack_in,
    input wire logic dl_ack_in,
    input wire logic dl_nack_in,
    input wire logic buf_free_in,
    input wire logic ul_msg_pend_in,
    input wire logic ul_msg_net_in,
    input wire logic tx_ready_in,
    input wire logic tx_done_in,
    output logic tx_valid_out,
    output logic [1:0] tx_kind_out,
    output logic [7:0] tx_data_out,
    output logic buf_store_out,
    output logic [1:0] buf_queue_out,
    output logic buf_mgmt_out,
    output logic exec_out,
    output logic [7:0] exec_cmd_out,
    output logic dl_discard_out,
    output logic ul_msg_sent_out,
    output logic ul_msg_drop_out,
    output logic [1:0] dl_state_out,
    output logic quench_out,
    output logic flush_out,
    output logic remote_out,
    output logic handshake_out
);
    // ------------------------------------------------------------------------
    // Configuration, caught once after reset release
    // ------------------------------------------------------------------------
    logic cfg_taken_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_taken_q <= 1'b0;
            remote_out <= 1'b0;
            handshake_out <= 1'b0;
        end else if (!cfg_taken_q) begin
            cfg_taken_q <= 1'b1;
            remote_out <= cfg_remote_in;
            handshake_out <= cfg_handshake_in;
        end
    end

    // Remote host mode also turns on the reliable transport
    wire reliable = remote_out;
    wire [31:0] gap_cyc = remote_out ? 32'(REMOTE_WAIT_CYC) : 32'(LOCAL_WAIT_CYC);

    // ------------------------------------------------------------------------
    // Downlink command decode
    // ------------------------------------------------------------------------
    ssf_pkg::ssf_dl_state_t dl_q, dl_d;
    logic [7:0] req_cmd_q;
    logic flush_d, quench_d;

    wire [3:0] cls = dl_cmd_in[`SSF_CLS_MSB:`SSF_CLS_LSB];
    wire [1:0] queue = dl_cmd_in[1:0];
    wire is_net = (cls == `SSF_CLS_NETWORK_MSG);
    wire is_mgmt = (cls == `SSF_CLS_LOCAL_MGMT);
    // In flush only management commands reach a buffer
    wire buf_allowed = (is_net || is_mgmt) && (!flush_out || is_mgmt);
    wire is_reset = (dl_cmd_in == `SSF_IFACE_RESET_CMD);
    wire is_quench = (dl_cmd_in == `SSF_UPLINK_QUENCH_CMD);
    wire is_resume = (dl_cmd_in == `SSF_UPLINK_RESUME_CMD);
    wire is_flush_on = (dl_cmd_in == `SSF_FLUSH_CMD) || (dl_cmd_in == `SSF_FLUSH_IGNORE_CMD);
    wire is_flush_off = (dl_cmd_in == `SSF_FLUSH_CANCEL_CMD);
    wire is_imm = is_reset || is_quench || is_resume || is_flush_on || is_flush_off
        || (dl_cmd_in == `SSF_GO_ONLINE_CMD) || (dl_cmd_in == `SSF_GO_OFFLINE_CMD)
        || (dl_cmd_in == `SSF_SLEEP_CMD) || (dl_cmd_in == `SSF_STATUS_QUERY_CMD);

    // Checksum and sequence are judged by the frame receiver
    wire frm_ok = dl_frame_in && dl_good_in;
    wire frm_bad = dl_frame_in && !dl_good_in;
    wire in_normal = (dl_q == ssf_pkg::SSF_DL_NORMAL);
    wire in_req = (dl_q == ssf_pkg::SSF_DL_REQUESTED);
    wire in_grant = (dl_q == ssf_pkg::SSF_DL_GRANTED);
    wire grant_ctl = is_quench || is_resume || is_reset;
    wire grant_match = dl_has_data_in && (cls == req_cmd_q[`SSF_CLS_MSB:`SSF_CLS_LSB]);

    // Immediate commands run in normal state; only a few in granted state
    wire exec_now = frm_ok && is_imm && (in_normal || (in_grant && grant_ctl));
    wire store_grant = frm_ok && in_grant && grant_match;
    wire fw_unreq = (`SSF_FW_VERSION >= `SSF_FW_UNREQ_MIN);
    wire unreq = frm_ok && in_normal && buf_allowed && dl_has_data_in && fw_unreq;
    wire store_unreq = unreq && buf_free_in;
    wire nack_unreq = unreq && !buf_free_in && reliable;
    wire request = frm_ok && in_normal && buf_allowed && !dl_has_data_in;

    // ------------------------------------------------------------------------
    // Downlink byte gap timer
    // ------------------------------------------------------------------------
    logic gap_run_q;
    logic gap_exp;

    ssf_timer u_gap_timer (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .start_in(dl_byte_in),
        .stop_in(dl_frame_in),
        .load_in(gap_cyc),
        .expired_out(gap_exp)
    );

    // Only a gap inside an unfinished frame counts
    wire gap_to = gap_exp && gap_run_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gap_run_q <= 1'b0;
        end else begin
            gap_run_q <= dl_byte_in || (gap_run_q && !dl_frame_in && !gap_exp);
        end
    end

    // ------------------------------------------------------------------------
    // Downlink buffer request states
    // ------------------------------------------------------------------------
    logic reply_pend_q;
    logic [7:0] reply_code_q;
    // Decided in the first cycle of the requested state; the host waits for it before asking again
    wire reply_set = in_req;

    always_comb begin
        dl_d = dl_q;
        case (dl_q)
            ssf_pkg::SSF_DL_NORMAL: begin
                if (request) begin
                    dl_d = ssf_pkg::SSF_DL_REQUESTED;
                end
            end
            ssf_pkg::SSF_DL_REQUESTED: begin
                if (reply_set) begin
                    dl_d = buf_free_in ? ssf_pkg::SSF_DL_GRANTED : ssf_pkg::SSF_DL_NORMAL;
                end
            end
            ssf_pkg::SSF_DL_GRANTED: begin
                // Any good frame but quench or resume ends the grant; a bad frame does not
                if (frm_ok && !(is_quench || is_resume)) begin
                    dl_d = ssf_pkg::SSF_DL_NORMAL;
                end
            end
            default: begin
                dl_d = ssf_pkg::SSF_DL_NORMAL;
            end
        endcase
        if (gap_to) begin
            dl_d = ssf_pkg::SSF_DL_NORMAL;
        end
    end

    assign flush_d = (exec_now && (is_flush_off || is_reset)) ? 1'b0
        : ((exec_now && is_flush_on) ? 1'b1 : flush_out);
    assign quench_d = (exec_now && (is_resume || is_reset)) ? 1'b0
        : ((exec_now && is_quench) ? 1'b1 : quench_out);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dl_q <= ssf_pkg::SSF_DL_NORMAL;
            req_cmd_q <= 8'h00;
            dl_state_out <= 2'h0;
            flush_out <= 1'b0;
            quench_out <= 1'b0;
        end else begin
            dl_q <= dl_d;
            dl_state_out <= dl_d;
            flush_out <= flush_d;
            quench_out <= quench_d;
            if (request) begin
                req_cmd_q <= dl_cmd_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            buf_store_out <= 1'b0;
            buf_queue_out <= 2'h0;
            buf_mgmt_out <= 1'b0;
            exec_out <= 1'b0;
            exec_cmd_out <= 8'h00;
            dl_discard_out <= 1'b0;
        end else begin
            buf_store_out <= store_grant || store_unreq;
            // A granted message keeps the queue named in its request
            buf_queue_out <= store_grant ? req_cmd_q[1:0] : queue;
            buf_mgmt_out <= store_grant ? (req_cmd_q[`SSF_CLS_MSB:`SSF_CLS_LSB]
                == `SSF_CLS_LOCAL_MGMT) : is_mgmt;
            exec_out <= exec_now;
            exec_cmd_out <= dl_cmd_in;
            dl_discard_out <= gap_to;
        end
    end

    // ------------------------------------------------------------------------
    // Uplink queue: single-byte answers first, then replies, then messages
    // ------------------------------------------------------------------------
    logic ack_pend_q, nack_pend_q;
    logic fifo_ready;
    logic ul_push;
    logic [9:0] ul_item;

    wire ack_set = reliable && frm_ok && !nack_unreq;
    wire nack_set = reliable && (frm_bad || gap_to || nack_unreq);
    wire push_nack = nack_pend_q && fifo_ready;
    wire push_ack = ack_pend_q && fifo_ready && !nack_pend_q;
    wire push_reply = reply_pend_q && fifo_ready && !nack_pend_q && !ack_pend_q;
    wire ul_slot = fifo_ready && !nack_pend_q && !ack_pend_q && !reply_pend_q;
    wire fifo_push = push_nack || push_ack || push_reply || ul_push;
    wire [9:0] fifo_item = push_nack ? {ssf_pkg::SSF_TX_RAW, `SSF_BYTE_NACK}
        : push_ack ? {ssf_pkg::SSF_TX_RAW, `SSF_BYTE_ACK}
        : push_reply ? {ssf_pkg::SSF_TX_REPLY, reply_code_q}
        : ul_item;

    // A new event in the cycle of its push keeps the flag set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_pend_q <= 1'b0;
            nack_pend_q <= 1'b0;
            reply_pend_q <= 1'b0;
            reply_code_q <= 8'h00;
        end else begin
            ack_pend_q <= ack_set || (ack_pend_q && !push_ack);
            nack_pend_q <= nack_set || (nack_pend_q && !push_nack);
            reply_pend_q <= reply_set || (reply_pend_q && !push_reply);
            if (reply_set) begin
                reply_code_q <= buf_free_in ? `SSF_BUFFER_GRANTED_REPLY
                    : `SSF_BUFFER_REFUSED_REPLY;
            end
        end
    end

    // Receiver stalls back up here instead of losing answers
    ssf_skid2 #(
        .WIDTH(10)
    ) u_tx_buf (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(fifo_push),
        .in_data_in(fifo_item),
        .in_ready_out(fifo_ready),
        .out_valid_out(tx_valid_out),
        .out_data_out({tx_kind_out, tx_data_out}),
        .out_ready_in(tx_ready_in)
    );

    // ------------------------------------------------------------------------
    // Uplink message sequencer
    // ------------------------------------------------------------------------
    ssf_pkg::ssf_ul_state_t ul_q, ul_d;
    logic [2:0] retry_q, retry_d;
    logic wait_exp, life_exp;
    logic wait_start, life_start;

    // Network traffic obeys quench and flush; responses always go
    wire ul_allowed = ul_msg_pend_in && (!ul_msg_net_in || (!quench_out && !flush_out));
    wire resend_to = handshake_out ? 1'b1 : 1'b0;
    wire [31:0] wait_load = (ul_q == ssf_pkg::SSF_UL_WAIT_END) ? 32'(ACK_WAIT_CYC) : gap_cyc;
    wire go_attn = ul_slot && (ul_q == ssf_pkg::SSF_UL_ATTN);
    wire go_body = ul_slot && (ul_q == ssf_pkg::SSF_UL_BODY);
    wire end_reliable = (ul_q == ssf_pkg::SSF_UL_WAIT_END) && tx_done_in && reliable;
    wire attn_abort = life_exp && ((ul_q == ssf_pkg::SSF_UL_ATTN)
        || (ul_q == ssf_pkg::SSF_UL_WAIT_ATTN));
    wire ack_to = wait_exp && (ul_q == ssf_pkg::SSF_UL_WAIT_ACK);
    wire retry_out = ack_to && (retry_q == `SSF_ACK_RETRY_MAX);

    assign ul_push = go_attn || go_body;
    assign ul_item = go_attn ? {ssf_pkg::SSF_TX_RAW, `SSF_BYTE_ATTN}
        : {ssf_pkg::SSF_TX_MSG, 8'h00};
    assign wait_start = go_attn || end_reliable;
    // Life clock restarts with every new attention phase
    assign life_start = handshake_out && (ul_q != ssf_pkg::SSF_UL_ATTN)
        && (ul_q != ssf_pkg::SSF_UL_WAIT_ATTN) && (ul_d == ssf_pkg::SSF_UL_ATTN);

    ssf_timer u_wait_timer (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .start_in(wait_start),
        .stop_in(dl_attn_ack_in || dl_ack_in || dl_nack_in),
        .load_in(wait_load),
        .expired_out(wait_exp)
    );

    ssf_timer u_life_timer (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .start_in(life_start),
        .stop_in(ul_q == ssf_pkg::SSF_UL_BODY),
        .load_in(32'(LIFE_CYC)),
        .expired_out(life_exp)
    );

    always_comb begin
        ul_d = ul_q;
        retry_d = retry_q;
        case (ul_q)
            ssf_pkg::SSF_UL_IDLE: begin
                retry_d = 3'h0;
                if (cfg_taken_q && ul_allowed) begin
                    // Buffered protocol skips the attention step
                    ul_d = handshake_out ? ssf_pkg::SSF_UL_ATTN : ssf_pkg::SSF_UL_BODY;
                end
            end
            ssf_pkg::SSF_UL_ATTN: begin
                if (go_attn) begin
                    ul_d = ssf_pkg::SSF_UL_WAIT_ATTN;
                end
            end
            ssf_pkg::SSF_UL_WAIT_ATTN: begin
                if (dl_attn_ack_in) begin
                    ul_d = ssf_pkg::SSF_UL_BODY;
                end else if (wait_exp) begin
                    ul_d = ssf_pkg::SSF_UL_ATTN;
                end
            end
            ssf_pkg::SSF_UL_BODY: begin
                if (go_body) begin
                    ul_d = ssf_pkg::SSF_UL_WAIT_END;
                end
            end
            ssf_pkg::SSF_UL_WAIT_END: begin
                if (tx_done_in) begin
                    ul_d = reliable ? ssf_pkg::SSF_UL_WAIT_ACK : ssf_pkg::SSF_UL_IDLE;
                end
            end
            ssf_pkg::SSF_UL_WAIT_ACK: begin
                if (dl_ack_in) begin
                    ul_d = ssf_pkg::SSF_UL_IDLE;
                end else if (dl_nack_in) begin
                    ul_d = resend_to ? ssf_pkg::SSF_UL_ATTN : ssf_pkg::SSF_UL_BODY;
                end else if (ack_to) begin
                    retry_d = retry_q + 3'h1;
                    ul_d = retry_out ? ssf_pkg::SSF_UL_IDLE
                        : (resend_to ? ssf_pkg::SSF_UL_ATTN : ssf_pkg::SSF_UL_BODY);
                end
            end
            default: begin
                ul_d = ssf_pkg::SSF_UL_IDLE;
            end
        endcase
        if (attn_abort) begin
            ul_d = ssf_pkg::SSF_UL_IDLE;
        end
    end

    wire sent_now = ((ul_q == ssf_pkg::SSF_UL_WAIT_END) && tx_done_in && !reliable)
        || ((ul_q == ssf_pkg::SSF_UL_WAIT_ACK) && dl_ack_in);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ul_q <= ssf_pkg::SSF_UL_IDLE;
            retry_q <= 3'h0;
            ul_msg_sent_out <= 1'b0;
            ul_msg_drop_out <= 1'b0;
        end else begin
            ul_q <= ul_d;
            retry_q <= retry_d;
            ul_msg_sent_out <= sent_now;
            ul_msg_drop_out <= attn_abort || (retry_out && !dl_ack_in && !dl_nack_in);
        end
    end
endmodule

// *** rtl/ssf_skid2.sv ***
// Two-entry buffer with valid and ready on both sides; outputs come from flops.
`timescale 1ns/1ps
module ssf_skid2 #(
    parameter int WIDTH = 10
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] skid_q;
    logic skid_v_q;
    wire push = in_valid_in && !skid_v_q;
    wire head_free = !out_valid_out || out_ready_in;

    assign in_ready_out = !skid_v_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            skid_q <= '0;
            skid_v_q <= 1'b0;
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end else if (head_free) begin
            // Older skid word goes out first to keep order
            out_valid_out <= skid_v_q || push;
            out_data_out <= skid_v_q ? skid_q : in_data_in;
            skid_v_q <= 1'b0;
        end else if (push) begin
            skid_q <= in_data_in;
            skid_v_q <= 1'b1;
        end
    end
endmodule

// *** rtl/ssf_timer.sv ***
// One-shot countdown timer with a one-cycle expiry pulse.
`timescale 1ns/1ps
module ssf_timer (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [31:0] load_in,
    output logic expired_out
);
    logic [31:0] cnt_q;
    logic run_q;
    wire last = run_q && (cnt_q == 32'h1);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            expired_out <= 1'b0;
        end else begin
            // A restart in the final cycle wins over the expiry
            expired_out <= last && !start_in && !stop_in;
            if (start_in) begin
                cnt_q <= load_in;
                run_q <= 1'b1;
            end else if (stop_in || last) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q - 32'h1;
            end
        end
    end
endmodule

// *** verif/ssf_host_model.sv ***
// Host model: takes uplink items, answers attention and acknowledges.
`timescale 1ns/1ps
module ssf_host_model (
    input wire logic clk_in,
    input wire logic remote_in,
    input wire logic mute_in,
    input wire logic tx_valid_in,
    input wire logic [1:0] tx_kind_in,
    input wire logic [7:0] tx_data_in,
    output logic ready_out,
    output logic done_out,
    output logic attn_ack_out,
    output logic ack_out
);
    initial {ready_out, done_out, attn_ack_out, ack_out} = '0;
    // Random stalls keep the two-entry item buffer under pressure
    always @(negedge clk_in) ready_out = 1'($urandom);
    always @(posedge clk_in) begin
        // A muted host never answers attention, so the message life can run out
        if (!mute_in && tx_valid_in && ready_out && tx_kind_in == 2'h0 && tx_data_in == 8'h01) begin
            repeat (3) @(negedge clk_in);
            attn_ack_out = 1'b1;
            @(negedge clk_in) attn_ack_out = 1'b0;
        end else if (tx_valid_in && ready_out && tx_kind_in == 2'h2) begin
            repeat (4) @(negedge clk_in);
            done_out = 1'b1;
            @(negedge clk_in) done_out = 1'b0;
            ack_out = remote_in;
            @(negedge clk_in) ack_out = 1'b0;
        end
    end
endmodule

// *** verif/ssf_session_assertions.sv ***
// Checker of the session flow top ports.
`timescale 1ns/1ps
module ssf_session_assertions (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic buf_free_in,
    input wire logic tx_ready_in,
    input wire logic tx_done_in,
    input wire logic tx_valid_out,
    input wire logic [1:0] tx_kind_out,
    input wire logic [7:0] tx_data_out,
    input wire logic buf_store_out,
    input wire logic exec_out,
    input wire logic [7:0] exec_cmd_out,
    input wire logic ul_msg_sent_out,
    input wire logic [1:0] dl_state_out,
    input wire logic remote_out,
    input wire logic handshake_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_req; dl_state_out == 2'h1; endsequence
    AST_GRANT: assert property (s_req ##0 buf_free_in |=> dl_state_out == 2'h3)
        else $error("no grant");
    AST_REFUSE: assert property (s_req ##0 !buf_free_in |=> dl_state_out == 2'h0)
        else $error("no refusal");
    AST_STORE: assert property (buf_store_out |-> dl_state_out == 2'h0)
        else $error("store off normal");
    AST_REPLY: assert property (tx_valid_out && tx_kind_out == 2'h1
        |-> tx_data_out inside {8'hC0, 8'hC1}) else $error("bad reply");
    AST_HOLD: assert property (tx_valid_out && !tx_ready_in
        |=> tx_valid_out && $stable(tx_data_out)) else $error("item lost");
    AST_EXEC: assert property (exec_out
        |-> exec_cmd_out inside {8'h50, [8'h60:8'h68]}) else $error("bad exec");
    AST_LOCAL: assert property (ul_msg_sent_out && !remote_out
        |-> $past(tx_done_in)) else $error("early sent");
    AST_ATTN: assert property (tx_valid_out && tx_data_out == 8'h01
        |-> handshake_out) else $error("attention when buffered");
endmodule
bind ssf_session_top ssf_session_assertions chk_u (.*);

// *** verif/tb_ssf_session_top.sv ***
// Bench of the session flow top with host model and note queue.
`timescale 1ns/1ps
module tb_ssf_session_top;
    logic clk_in = 1'b0;
    logic rst_b_in, cfg_remote_in, cfg_handshake_in, dl_byte_in, dl_frame_in, dl_has_data_in;
    logic dl_good_in, dl_nack_in, buf_free_in, ul_msg_pend_in, ul_msg_net_in, dl_attn_ack_in;
    logic dl_ack_in, tx_ready_in, tx_done_in, tx_valid_out, buf_store_out, buf_mgmt_out;
    logic exec_out, dl_discard_out, ul_msg_sent_out, ul_msg_drop_out, quench_out, flush_out;
    logic remote_out, handshake_out, host_mute;
    logic [1:0] tx_kind_out, buf_queue_out, dl_state_out, q;
    logic [7:0] dl_cmd_in, tx_data_out, exec_cmd_out, c;
    logic [8:0] notes[$];
    int err_count = 0, cmp_count = 0, n;
    ssf_session_top #(.LOCAL_WAIT_CYC(20), .REMOTE_WAIT_CYC(50), .LIFE_CYC(200),
        .ACK_WAIT_CYC(60)) dut_u (.*);
    ssf_host_model host_u (.clk_in, .remote_in(remote_out), .mute_in(host_mute),
        .tx_valid_in(tx_valid_out),
        .tx_kind_in(tx_kind_out), .tx_data_in(tx_data_out), .ready_out(tx_ready_in),
        .done_out(tx_done_in), .attn_ack_out(dl_attn_ack_in), .ack_out(dl_ack_in));
    initial forever #5 clk_in = ~clk_in;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares=%0d errors=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic frm(input logic [7:0] cmd, input logic data);
        @(negedge clk_in);
        {dl_cmd_in, dl_has_data_in, dl_frame_in} = {cmd, data, 1'b1};
        @(negedge clk_in) dl_frame_in = 1'b0;
    endtask
    always @(negedge clk_in) begin
        if (exec_out === 1'b1) chk({1'b0, exec_cmd_out}, notes.pop_front());
        if (buf_store_out === 1'b1)
            chk({6'h20, buf_mgmt_out, buf_queue_out}, notes.pop_front());
        if (ul_msg_sent_out === 1'b1) chk(9'h1FF, notes.pop_front());
        if (ul_msg_drop_out === 1'b1) chk(9'h1AA, notes.pop_front());
        if (dl_discard_out === 1'b1) chk(9'h1DD, notes.pop_front());
    end
    initial begin
        {rst_b_in, dl_byte_in, dl_frame_in, dl_has_data_in, dl_nack_in, buf_free_in} = '0;
        {ul_msg_pend_in, ul_msg_net_in, dl_cmd_in, host_mute, dl_good_in} = 12'h1;
        void'($urandom(68208));
        // Pass 0: local host, buffered link; pass 1: remote host, handshaked link
        for (int m = 0; m < 2; m++) begin
            {rst_b_in, cfg_remote_in, cfg_handshake_in} = {1'b0, m[0], m[0]};
            repeat (8) @(negedge clk_in);
            rst_b_in = 1'b1;
            repeat (2) @(negedge clk_in);
            chk({remote_out, handshake_out}, {m[0], m[0]});
            for (int i = 0; i < 10; i++) begin
                c = (i == 0) ? 8'h50 : 8'h69 - 8'(i);
                notes.push_back({1'b0, c});
                frm(c, 1'b0);
            end
            // Quench came after resume, flush cancel came last
            chk({quench_out, flush_out}, 2'h2);
            q = 2'($urandom);
            frm({6'h04, q}, 1'b0);
            @(negedge clk_in) buf_free_in = 1'b1;
            frm({6'h04, q}, 1'b0);
            @(negedge clk_in) chk(9'(dl_state_out), 9'h3);
            frm(8'h67, 1'b0);
            chk(9'(dl_state_out), 9'h0);
            frm({6'h08, q}, 1'b0);
            notes.push_back({7'h41, q});
            notes.push_back({7'h40, q});
            // Data frame only after the grant has come back
            frm({6'h08, ~q}, 1'b1);
            frm({6'h04, q}, 1'b1);
            // A network message waits while quench stands, then goes after resume
            {ul_msg_net_in, ul_msg_pend_in} = 2'h3;
            repeat (30) @(negedge clk_in);
            notes.push_back(9'h066);
            frm(8'h66, 1'b0);
            notes.push_back(9'h1FF);
            for (int i = 0; i < 500 && ul_msg_sent_out !== 1'b1; i++) @(negedge clk_in);
            ul_msg_net_in = 1'b0;
            ul_msg_pend_in = m[0];
            if (m == 1) begin
                host_mute = 1'b1;
                notes.push_back(9'h1AA);
                for (n = 0; n < 500 && ul_msg_drop_out !== 1'b1; n++) @(negedge clk_in);
                chk(9'(n >= 200 && n <= 210), 9'h1);
                {ul_msg_pend_in, host_mute} = '0;
            end
            notes.push_back(9'h1DD);
            @(negedge clk_in) dl_byte_in = 1'b1;
            @(negedge clk_in) dl_byte_in = 1'b0;
            repeat (60) @(negedge clk_in);
            buf_free_in = 1'b0;
        end
        chk(9'(notes.size()), 9'h0);
        summarize();
    end
    initial begin
        #50us;
        err_count++;
        summarize();
    end
endmodule
